/* File: adc_seq_pkg.sv */
// Constants and types shared by the converter command sequencer.
// Assumes a 200 MHz system clock; every cycle count below is derived from it.
package adc_seq_pkg;
   // Command bytes
   localparam logic [7:0] CMD_RESET = 8'h06;
   localparam logic [7:0] CMD_WRITE = 8'h40;
   localparam logic [7:0] CMD_READ_CFG = 8'h20;
   localparam logic [7:0] CMD_START = 8'h08;
   localparam logic [7:0] CMD_READ_DATA = 8'h10;
   localparam logic [7:0] CMD_SLEEP = 8'h02;
   // Configuration byte layout and reset value
   typedef struct packed {
      logic [2:0] input_selector; // Input pair select
      logic gain4;                // Gain of four
      logic [1:0] rate;           // Data-rate select
      logic continuous;           // Continuous conversion
      logic ext_ref;              // External reference
   } cfg_t;
   localparam cfg_t CFG_RESET = 8'h00;
   localparam logic [2:0] MUX_SHORTED = 3'h7;
   localparam logic [1:0] RATE_20 = 2'h0;
   localparam logic [1:0] RATE_90 = 2'h1;
   localparam logic [1:0] RATE_330 = 2'h2;
   // Timing
   localparam int CLK_MHZ = 200;
   localparam int POR_TIME_US = 500;
   localparam int POR_CYC = POR_TIME_US * CLK_MHZ;
   localparam real CONV_TIME_90_MS = 11.3;
   localparam int CONV_CYC_90 = int'($floor(CONV_TIME_90_MS * 1000.0 * CLK_MHZ));
   localparam int CONV_CYC_20 = CLK_MHZ * 1000000 / 20;
   localparam int CONV_CYC_330 = CLK_MHZ * 1000000 / 330;
   localparam int CONV_CYC_1000 = CLK_MHZ * 1000000 / 1000;
   // Bus framing
   localparam logic [3:0] CNT_BYTE = 4'h8;
   localparam logic [3:0] CNT_LAST = 4'h7;
   localparam int FIFO_DEPTH = 8;
   // Result coding
   localparam logic signed [25:0] FS_IN = 26'sh0800000;
   localparam logic signed [27:0] POS_LIM = 28'sh07fffff;
   localparam logic signed [27:0] NEG_LIM = 28'shf800000;
   localparam logic [23:0] FULL_POS = 24'h7fffff;
endpackage

/* File: adc_command_sequencer.sv */
// Byte FIFO and command sequencer of a 24-bit converter on a two-wire bus.
// Assumes scl/sda arrive asynchronously and the analog codes come from
// modulator logic on sys_clk.
`timescale 1ns/1ps

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,            // System clock
   input wire logic nrst,               // Synchronous reset, low
   input wire logic in_valid,           // Write request
   output logic in_ready,               // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word written
   output logic out_valid,              // Word available
   input wire logic out_ready,          // Read request
   output logic [WIDTH-1:0] out_data    // Oldest word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH]; // Storage
   logic [AW:0] wr_q;               // Write pointer with wrap bit
   logic [AW:0] rd_q;               // Read pointer with wrap bit
   logic [AW:0] fill;               // Words held

   assign fill = wr_q - rd_q;
   assign in_ready = fill != (AW+1)'(DEPTH);
   assign out_valid = fill != '0;
   assign out_data = mem_q[rd_q[AW-1:0]];

   // Storage write
   always_ff @(posedge sys_clk) begin
      if (in_valid && in_ready) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

module adc_command_sequencer #(
   parameter int POR_CYCLES = adc_seq_pkg::POR_CYC,
   parameter int CONV20 = adc_seq_pkg::CONV_CYC_20,
   parameter int CONV90 = adc_seq_pkg::CONV_CYC_90,
   parameter int CONV330 = adc_seq_pkg::CONV_CYC_330,
   parameter int CONV1000 = adc_seq_pkg::CONV_CYC_1000,
   parameter logic [6:0] BUS_ADDR = 7'h40
) (
   input wire logic sys_clk,                    // System clock
   input wire logic nrst,                       // Synchronous reset, low
   input wire logic ce,                         // Clock enable
   input wire logic scl_in,                     // Bus clock level
   input wire logic sda_in,                     // Bus data level
   input wire logic signed [25:0] vin_frac,     // Input over reference, 2^23 scale
   input wire logic signed [25:0] offset_frac,  // Shorted-input offset, same scale
   output logic sda_out,                        // Data drive value, always low
   output logic sda_oe,                         // Data pulled low
   output logic result_ready_n,                 // Result ready, low active
   output logic result_new_q,                   // New result waiting
   output adc_seq_pkg::cfg_t cfg_q,             // Configuration byte
   output logic run_q,                          // Converting
   output logic sleep_q                         // Powered down
);
   import adc_seq_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001, S_RX = 5'b00010, S_ACK = 5'b00100,
      S_TX = 5'b01000, S_MACK = 5'b10000
   } bus_st_t;

   logic scl_m_q, scl_s_q, scl_p_q; // Clock synchroniser and history
   logic sda_m_q, sda_s_q, sda_p_q; // Data synchroniser and history
   logic start_c, stop_c, rise, fall;
   bus_st_t st_q;                   // Bus state
   logic [3:0] cnt_q;               // Bit count
   logic [7:0] sh_q;                // Shift register
   logic addr_ph_q;                 // Address byte phase
   logic rw_q;                      // Read transfer
   logic mack_q;                    // Host acked last byte
   logic [1:0] idx_q;               // Reply byte index
   logic [23:0] reply_q;            // Reply bytes, first in top
   logic [31:0] por_cnt_q;          // Power-on wait
   logic por_done_q;                // Power-on finished
   logic push, pop, fifo_in_ready, fifo_out_valid;
   logic [7:0] cmd;                 // Oldest queued byte
   logic pend_wr_q;                 // Next byte is configuration
   logic [31:0] conv_cnt_q;         // Conversion timer
   logic conv_done, clr_new;
   logic [23:0] result_q;           // Latest result
   logic [7:0] next_byte;           // Reply byte at idx_q

   function automatic logic [31:0] conv_period(input logic [1:0] r);
      unique case (r)
         RATE_20: conv_period = 32'(CONV20);
         RATE_90: conv_period = 32'(CONV90);
         RATE_330: conv_period = 32'(CONV330);
         default: conv_period = 32'(CONV1000);
      endcase
   endfunction

   function automatic logic [23:0] scale(input logic signed [25:0] v, input logic g4);
      logic signed [27:0] p;
      p = g4 ? ({{2{v[25]}}, v} <<< 2) : {{2{v[25]}}, v};
      if (p > POS_LIM) begin
         scale = POS_LIM[23:0];
      end else if (p < NEG_LIM) begin
         scale = NEG_LIM[23:0];
      end else begin
         scale = p[23:0];
      end
   endfunction

   function automatic logic [7:0] byte_sel(input logic [23:0] r, input logic [1:0] i);
      unique case (i)
         2'h0: byte_sel = r[23:16];
         2'h1: byte_sel = r[15:8];
         2'h2: byte_sel = r[7:0];
         default: byte_sel = 8'h00;
      endcase
   endfunction

   function automatic logic is_cmd(input logic [7:0] c);
      is_cmd = pop && !pend_wr_q && cmd == c;
   endfunction

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      end else if (ce) begin
         {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
      end
   end

   assign start_c = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   assign stop_c = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
   assign rise = scl_s_q && !scl_p_q;
   assign fall = !scl_s_q && scl_p_q;
   // Reply byte picked once, so its top bit can be read
   assign next_byte = byte_sel(reply_q, idx_q);

   // Power-on wait, no acknowledge until done
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         por_cnt_q <= '0;
         por_done_q <= 1'b0;
      end else if (ce && !por_done_q) begin
         por_cnt_q <= por_cnt_q + 1'b1;
         por_done_q <= por_cnt_q == 32'(POR_CYCLES - 1);
      end
   end

   // Bus target state machine
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_q <= S_IDLE;
         cnt_q <= '0;
         sh_q <= '0;
         addr_ph_q <= 1'b0;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         idx_q <= '0;
         sda_oe <= 1'b0;
      end else if (ce) begin
         if (stop_c) begin
            st_q <= S_IDLE;
            sda_oe <= 1'b0;
         end else if (start_c) begin
            st_q <= S_RX;
            addr_ph_q <= 1'b1;
            cnt_q <= '0;
            sda_oe <= 1'b0;
         end else begin
            unique case (st_q)
               S_IDLE: ;
               S_RX: if (rise) begin
                  sh_q <= {sh_q[6:0], sda_s_q};
                  cnt_q <= cnt_q + 1'b1;
               end else if (fall && cnt_q == CNT_BYTE) begin
                  cnt_q <= '0;
                  // Address match or room to queue acks, else released
                  if (addr_ph_q ? (sh_q[7:1] == BUS_ADDR && por_done_q) : fifo_in_ready) begin
                     sda_oe <= 1'b1;
                     st_q <= S_ACK;
                     if (addr_ph_q) begin
                        rw_q <= sh_q[0];
                        idx_q <= '0;
                     end
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
               S_ACK: if (fall) begin
                  addr_ph_q <= 1'b0;
                  if (rw_q && addr_ph_q) begin
                     sh_q <= next_byte;
                     sda_oe <= !next_byte[7];
                     idx_q <= idx_q + 1'b1;
                     st_q <= S_TX;
                  end else begin
                     sda_oe <= 1'b0;
                     st_q <= S_RX;
                  end
               end
               S_TX: if (fall) begin
                  if (cnt_q == CNT_LAST) begin
                     cnt_q <= '0;
                     sda_oe <= 1'b0;
                     st_q <= S_MACK;
                  end else begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_oe <= !sh_q[6];
                     cnt_q <= cnt_q + 1'b1;
                  end
               end
               S_MACK: if (rise) begin
                  mack_q <= !sda_s_q;
               end else if (fall) begin
                  if (mack_q) begin
                     sh_q <= next_byte;
                     sda_oe <= !next_byte[7];
                     idx_q <= idx_q + 1'b1;
                     st_q <= S_TX;
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end

   // Written bytes queue for the command interpreter
   assign push = ce && st_q == S_RX && fall && cnt_q == CNT_BYTE && !addr_ph_q && !stop_c && !start_c;
   assign pop = fifo_out_valid && ce && st_q != S_TX && st_q != S_MACK;

   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(sh_q),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(cmd)
   );

   // Open-drain data only ever pulls low
   always_ff @(posedge sys_clk) begin
      sda_out <= 1'b0;
   end

   // Command interpreter
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cfg_q <= CFG_RESET;
         pend_wr_q <= 1'b0;
         reply_q <= '0;
         run_q <= 1'b0;
         sleep_q <= 1'b0;
      end else if (ce) begin
         // Single-shot stops after its result
         if (conv_done && !cfg_q.continuous) begin
            run_q <= 1'b0;
         end
         if (pop && pend_wr_q) begin
            cfg_q <= cmd;
            pend_wr_q <= 1'b0;
         end else if (pop) begin
            case (cmd)
               CMD_RESET: begin
                  cfg_q <= CFG_RESET;
                  run_q <= 1'b0;
                  sleep_q <= 1'b0;
               end
               CMD_WRITE: pend_wr_q <= 1'b1;
               CMD_READ_CFG: reply_q <= {cfg_q, 16'h0000};
               CMD_START: begin
                  run_q <= 1'b1;
                  sleep_q <= 1'b0;
               end
               CMD_READ_DATA: reply_q <= result_q;
               CMD_SLEEP: begin
                  run_q <= 1'b0;
                  sleep_q <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   assign conv_done = run_q && conv_cnt_q >= conv_period(cfg_q.rate) - 1'b1;
   // Written out, a function of constants alone would never re-evaluate
   assign clr_new = pop && !pend_wr_q && (cmd == CMD_READ_DATA || cmd == CMD_RESET);

   // Conversion timer, result and ready flag
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         conv_cnt_q <= '0;
         result_q <= '0;
         result_new_q <= 1'b0;
         result_ready_n <= 1'b1;
      end else if (ce) begin
         // New configuration restarts the running conversion
         if (!run_q || conv_done || is_cmd(CMD_START) || (pop && pend_wr_q)) begin
            conv_cnt_q <= '0;
         end else begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
         end
         if (conv_done) begin
            result_q <= scale(cfg_q.input_selector == MUX_SHORTED ? offset_frac : vin_frac, cfg_q.gain4);
            result_new_q <= 1'b1;
            result_ready_n <= result_new_q;
         end else begin
            result_new_q <= result_new_q && !clr_new;
            result_ready_n <= !(result_new_q && !clr_new);
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_done;
      ce && conv_done;
   endsequence

   property p_reset; is_cmd(CMD_RESET) |=> cfg_q == CFG_RESET && !run_q; endproperty
   a_reset: assert property (p_reset) else $error("reset command ignored");
   property p_write; pop && pend_wr_q |=> cfg_q == $past(cmd); endproperty
   a_write: assert property (p_write) else $error("config write lost");
   property p_rdcfg; is_cmd(CMD_READ_CFG) |=> reply_q[23:16] == cfg_q; endproperty
   a_rdcfg: assert property (p_rdcfg) else $error("config readback wrong");
   property p_start; is_cmd(CMD_START) |=> run_q && conv_cnt_q == 32'h0; endproperty
   a_start: assert property (p_start) else $error("start ignored");
   property p_data; is_cmd(CMD_READ_DATA) |=> reply_q == $past(result_q); endproperty
   a_data: assert property (p_data) else $error("data reply wrong");
   property p_sleep; is_cmd(CMD_SLEEP) |=> !run_q && sleep_q; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep ignored");
   property p_ready; s_done and !result_new_q |=> !result_ready_n && result_new_q; endproperty
   a_ready: assert property (p_ready) else $error("ready not asserted");
   property p_clear; is_cmd(CMD_READ_DATA) && !conv_done |=> !result_new_q && result_ready_n; endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");
   property p_refresh; s_done and result_new_q |=> result_ready_n && result_new_q; endproperty
   a_refresh: assert property (p_refresh) else $error("no ready refresh");
   property p_mux;
      s_done and cfg_q.input_selector == MUX_SHORTED |=>
         result_q == scale($past(offset_frac), $past(cfg_q.gain4));
   endproperty
   a_mux: assert property (p_mux) else $error("shorted input not used");
   property p_fs;
      s_done and vin_frac == FS_IN && !cfg_q.gain4 && cfg_q.input_selector != MUX_SHORTED |=> result_q == FULL_POS;
   endproperty
   a_fs: assert property (p_fs) else $error("full scale wrong");
   property p_period; s_done and $stable(cfg_q) |-> conv_cnt_q + 1'b1 == conv_period(cfg_q.rate); endproperty
   a_period: assert property (p_period) else $error("conversion time wrong");
endmodule

/* File: bus_host_model.sv */
// Two-wire bus controller standing in for the host microcontroller.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps

module bus_host_model #(
   parameter int HALF = 48
) (
   output logic scl,      // Bus clock, idle high
   output logic sda_oe,   // High pulls data low
   input wire logic sda   // Resolved data line
);
   // Idle bus, both lines released
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   // no stretch support
   // One bit: data set mid-low, sampled mid-high
   task automatic bit_slot(input logic b, output logic s);
      #(HALF/2) sda_oe = ~b;
      #(HALF/2) scl = 1'b1;
      #(HALF/2) s = sda;
      #(HALF/2) scl = 1'b0;
   endtask

   // Start or repeated start
   task automatic start();
      #(HALF/2) sda_oe = 1'b0;
      #(HALF/2) scl = 1'b1;
      #(HALF/2) sda_oe = 1'b1;
      #(HALF/2) scl = 1'b0;
   endtask

   // Stop, clock then stands high
   task automatic stop();
      #(HALF/2) sda_oe = 1'b1;
      #(HALF/2) scl = 1'b1;
      #(HALF/2) sda_oe = 1'b0;
      #(HALF);
   endtask

   // Byte out, MSB first, ack returned
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], s);
      end
      bit_slot(1'b1, s);
      ack = ~s;
   endtask

   // Byte in, then ack or nack
   task automatic read_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, s);
         d[i] = s;
      end
      bit_slot(nack, s);
   endtask
endmodule

/* File: adc_command_sequencer_bench.sv */
// Self-checking bench for the converter command sequencer and its FIFO.
// Assumes the host model drives the bus; inputs change 1 ns after sys_clk.
`timescale 1ns/1ps

module adc_command_sequencer_bench;
   import adc_seq_pkg::*;
   localparam int POR = 400;         // Shortened power-on wait
   localparam int P90 = 120;         // Shortened 90 SPS period
   localparam int LIMIT = 40000;     // Run ceiling in cycles
   localparam logic [7:0] ADDR_W = 8'h80; // Default address, write
   logic sys_clk = 1'b0;             // System clock
   logic nrst = 1'b0;                // Reset, low active
   logic signed [25:0] vin_frac = '0;    // Input code
   logic signed [25:0] offset_frac = '0; // Offset code
   logic sda_out, sda_oe, result_ready_n, result_new_q, run_q, sleep_q;
   cfg_t cfg_q;                      // Config byte seen
   logic scl, host_oe, sda_line;     // Bus wires
   logic ce = 1'b1;                  // Clock enable
   int error_cnt = 0;
   int comparisons = 0;
   int cycle_cnt = 0;
   logic [31:0] got;
   logic [31:0] got2;                // Second offset reading
   int ofs;                          // Averaged signed offset
   int n;

   // Open-drain data line with pull-up
   assign sda_line = ~(host_oe | (sda_oe & ~sda_out));

   always #2.5 sys_clk = ~sys_clk;

   adc_command_sequencer #(.POR_CYCLES(POR), .CONV20(160), .CONV90(P90), .CONV330(100), .CONV1000(80)) i_dut (
      .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .scl_in(scl), .sda_in(sda_line),
      .vin_frac(vin_frac), .offset_frac(offset_frac), .sda_out(sda_out), .sda_oe(sda_oe),
      .result_ready_n(result_ready_n), .result_new_q(result_new_q), .cfg_q(cfg_q),
      .run_q(run_q), .sleep_q(sleep_q));

   bus_host_model #(.HALF(24)) i_host (.scl(scl), .sda_oe(host_oe), .sda(sda_line));

   // Closing report
   task automatic print_verdict();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Single-bit compare
   task automatic check_bit(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Value compare
   task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Write transaction: command and optional data byte
   task automatic wr(input logic [7:0] c, input bit has_d, input logic [7:0] d);
      logic a;
      i_host.start();
      i_host.write_byte(ADDR_W, a);
      i_host.write_byte(c, a);
      if (has_d) begin
         i_host.write_byte(d, a);
      end
      check_bit("write_ack", 1'b1, a);
      i_host.stop();
      @(posedge sys_clk);
      #1;
   endtask

   // Command then repeated start and n reply bytes
   task automatic rd(input logic [7:0] c, input int cnt, output logic [31:0] g);
      logic a;
      logic [7:0] b;
      g = '0;
      i_host.start();
      i_host.write_byte(ADDR_W, a);
      i_host.write_byte(c, a);
      i_host.start();
      i_host.write_byte(ADDR_W | 8'h01, a);
      check_bit("read_addr_ack", 1'b1, a);
      for (int i = 0; i < cnt; i++) begin
         i_host.read_byte(i == cnt - 1, b);
         g = {g[23:0], b};
      end
      i_host.stop();
      @(posedge sys_clk);
      #1;
   endtask

   // Bounded wait for a level on the ready pin
   task automatic wait_lvl(input logic lvl, output int k);
      k = 0;
      while (result_ready_n !== lvl && k < 1000) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
   endtask

   // Single conversion, then three-byte read
   task automatic conv_read(input logic [7:0] cfg, input logic [31:0] e, output logic [31:0] g);
      int k;
      wr(CMD_WRITE, 1'b1, cfg);
      wr(CMD_START, 1'b0, 8'h00);
      wait_lvl(1'b0, k);
      check_bit("ready_low", 1'b0, result_ready_n);
      rd(CMD_READ_DATA, 3, g);
      check_val("result", e, g);
      check_bit("single_shot_stop", 1'b0, run_q);
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cycle_cnt <= cycle_cnt + 1;
      if (cycle_cnt == LIMIT) begin
         error_cnt++;
         print_verdict();
      end
   end

   logic ack;
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 nrst = 1'b1;
      @(posedge sys_clk);
      #1;
      check_val("reset_state", 32'h0000_0001, {cfg_q, sda_oe, result_new_q, run_q, sleep_q, result_ready_n});
      i_host.start();
      i_host.write_byte(ADDR_W, ack);
      i_host.stop();
      check_bit("por_ack", 1'b0, ack);
      // Low clock enable holds the power-on wait, so still refused
      @(posedge sys_clk);
      #1 ce = 1'b0;
      repeat (POR) @(posedge sys_clk);
      #1 ce = 1'b1;
      i_host.start();
      i_host.write_byte(ADDR_W, ack);
      i_host.stop();
      check_bit("ce_freeze", 1'b0, ack);
      repeat (POR) @(posedge sys_clk);
      #1;
      // Several commands in one transfer pass the queue in order
      i_host.start();
      i_host.write_byte(ADDR_W, ack);
      i_host.write_byte(CMD_WRITE, ack);
      i_host.write_byte(8'h16, ack);
      i_host.write_byte(CMD_START, ack);
      i_host.write_byte(CMD_SLEEP, ack);
      check_bit("queue_ack", 1'b1, ack);
      i_host.stop();
      @(posedge sys_clk);
      #1;
      check_val("queue_cfg", 32'h16, {24'h0, cfg_q});
      check_val("queue_order", 32'h2, {30'h0, sleep_q, run_q});
      wr(CMD_RESET, 1'b0, 8'h00);
      wr(CMD_WRITE, 1'b1, 8'h12);
      check_val("cfg", 32'h12, {24'h0, cfg_q});
      rd(CMD_READ_CFG, 2, got);
      check_val("cfg_readback", 32'h1200, got);
      wr(CMD_RESET, 1'b0, 8'h00);
      check_val("cfg_after_reset", 32'h0, {24'h0, cfg_q});
      // Continuous, gain 4, 90 SPS
      vin_frac = 26'sh0012345;
      wr(CMD_WRITE, 1'b1, 8'h16);
      wr(CMD_START, 1'b0, 8'h00);
      check_bit("run", 1'b1, run_q);
      wait_lvl(1'b0, n);
      check_bit("ready_fall", 1'b0, result_ready_n);
      vin_frac = 26'sh0023456;
      wait_lvl(1'b1, n);
      check_val("conv_cycles", P90, 32'(n));
      @(posedge sys_clk);
      #1;
      check_bit("ready_refresh", 1'b0, result_ready_n);
      wr(CMD_SLEEP, 1'b0, 8'h00);
      check_val("sleep", 32'h2, {30'h0, sleep_q, run_q});
      vin_frac = 26'sh0011111;
      repeat (3 * P90) @(posedge sys_clk);
      #1;
      rd(CMD_READ_DATA, 4, got);
      check_val("result_bytes", 32'h08d15800, got);
      check_val("flag_clear", 32'h1, {30'h0, result_new_q, result_ready_n});
      // Scaling and saturation at both ends of the range
      vin_frac = FS_IN;
      conv_read(8'h04, {8'h00, FULL_POS}, got);
      vin_frac = -26'sh0300000;
      conv_read(8'h14, 32'h00800000, got);
      // Offset calibration: average two shorted readings
      offset_frac = -26'sd5;
      conv_read(8'he4, 32'h00fffffb, got);
      conv_read(8'he4, 32'h00fffffb, got2);
      ofs = ($signed(got[23:0]) + $signed(got2[23:0])) / 2;
      vin_frac = 26'sh0100000;
      conv_read(8'h04, 32'h00100000, got);
      // Host removes the signed offset from a later reading
      check_val("compensated", 32'h00100005, 32'($signed(got[23:0]) - ofs));
      print_verdict();
   end
endmodule
